//--- verilog/pmar_regs.vh
// Purpose: Constants for the medium attachment register bank.
// Assumes: 16-bit registers reached through the device's register access port.
// Notes: Offsets are the in-map addresses; map select chooses the map.
// Function
// - Writing reset bit starts whole-device soft reset.
// - Reset bit self-clears when reset sequence completes.
// - Transmit disable powers down transmitter, ignores requests.
// - Multi-drop enable reads one, not writable.
// - Loopback bit shared with standard management control.
// - Low-power control and ability read zero.
// - Loopback ability bit always reads one.
// - Receive-fault ability bit always reads one.
// - Multi-drop ability bit always reads one.
// - Remote jabber mirrors standard management status bit.
// - Remote jabber latches high, clears on read.
// - Test-mode field selects five codes, rest reserved.
// - Test-mode field resets to normal operation.
// - Revision register read-only: major, minor, stage, patch.
// - Loopback returns MAC data through coding stages.
`ifndef PMAR_REGS_VH
`define PMAR_REGS_VH
`define PMAR_MAP_THREE        3'h3
`define PMAR_MAP_FOUR         3'h4
`define PMAR_ADDR_CONTROL     16'h08F9
`define PMAR_ADDR_STATUS      16'h08FA
`define PMAR_ADDR_TEST        16'h08FB
`define PMAR_ADDR_REVISION    16'h8000
`define PMAR_CTL_RESET_BIT    15
`define PMAR_CTL_TXDIS_BIT    14
`define PMAR_CTL_LOWPWR_BIT   11
`define PMAR_CTL_MDROP_BIT    10
`define PMAR_CTL_LOOP_BIT     0
`define PMAR_STA_LOOPAB_BIT   13
`define PMAR_STA_LOWPWR_BIT   11
`define PMAR_STA_MDROP_BIT    10
`define PMAR_STA_RXFLT_BIT    9
`define PMAR_STA_JABBER_BIT   1
`define PMAR_TEST_LSB         13
`define PMAR_TEST_NORMAL      3'h0
`define PMAR_TEST_VOLTAGE     3'h1
`define PMAR_TEST_DROOP       3'h2
`define PMAR_TEST_MASK        3'h3
`define PMAR_TEST_HIGHZ       3'h4
`define PMAR_REV_MAJOR_LSB    12
`define PMAR_REV_MINOR_LSB    8
`define PMAR_REV_STAGE_LSB    6
`define PMAR_REV_PATCH_LSB    0
`define PMAR_RESET_CYCLES     8'h10
`endif

//--- verilog/pmar_bank.v
// Purpose: Medium attachment control, status, test-mode and revision registers.
// Assumes: One register access per cycle; read strobe marks a host read.
// Notes: The soft reset output is a single pulse held for a fixed count.
`timescale 1ns/1ps
`default_nettype none
`include "pmar_regs.vh"
module pmar_bank
#(
   parameter [3:0] REV_MAJOR = 4'h2, // Arbitrary value.
   parameter [3:0] REV_MINOR = 4'h5, // Arbitrary value.
   parameter [1:0] REV_STAGE = 2'h1, // Arbitrary value.
   parameter [5:0] REV_PATCH = 6'h0A // Arbitrary value.
)
(
   input  wire        clk,
   input  wire        rst,
   input  wire [2:0]  map_select,
   input  wire [15:0] reg_addr,
   input  wire        reg_write,
   input  wire        reg_read,
   input  wire [15:0] reg_wdata,
   output reg  [15:0] reg_rdata,
   output wire        reg_hit,
   input  wire        std_loop_write,
   input  wire        std_loop_wdata,
   output wire        std_loop,
   input  wire        std_jabber_clear,
   input  wire        jabber_event,
   output wire        std_jabber,
   input  wire        mac_tx_req,
   output wire        mac_tx_grant,
   output wire        tx_power_down,
   output wire        loop_enable,
   output wire [2:0]  test_mode,
   output wire        soft_reset
);
   reg        loopback;
   reg        tx_disable;
   reg        jabber;
   reg [2:0]  test_sel;
   reg [7:0]  reset_count;
   reg        reset_busy;
   wire       sel_ctl;
   wire       sel_sta;
   wire       sel_tst;
   wire       sel_rev;

   function hit;
      input [2:0]  map;
      input [15:0] addr;
      input [2:0]  want_map;
      input [15:0] want_addr;
      begin
         hit = (map == want_map) && (addr == want_addr);
      end
   endfunction

   assign sel_ctl = hit(map_select, reg_addr, `PMAR_MAP_THREE, `PMAR_ADDR_CONTROL);
   assign sel_sta = hit(map_select, reg_addr, `PMAR_MAP_THREE, `PMAR_ADDR_STATUS);
   assign sel_tst = hit(map_select, reg_addr, `PMAR_MAP_THREE, `PMAR_ADDR_TEST);
   assign sel_rev = hit(map_select, reg_addr, `PMAR_MAP_FOUR, `PMAR_ADDR_REVISION);
   assign reg_hit = sel_ctl | sel_sta | sel_tst | sel_rev;

   // Soft reset: a write of one starts a counted sequence; the bit reads one until done.
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         reset_busy  <= 1'b0;
         reset_count <= 8'h00;
      end
      else if (reset_busy)
      begin
         if (reset_count == 8'h01)
            reset_busy <= 1'b0;
         reset_count <= reset_count - 8'h01;
      end
      else if (reg_write && sel_ctl && reg_wdata[`PMAR_CTL_RESET_BIT])
      begin
         reset_busy  <= 1'b1;
         reset_count <= `PMAR_RESET_CYCLES;
      end
   end
   assign soft_reset = reset_busy;

   // Control and test registers return to defaults on the soft reset too.
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         loopback   <= 1'b0;
         tx_disable <= 1'b0;
         test_sel   <= `PMAR_TEST_NORMAL;
      end
      else if (reset_busy)
      begin
         loopback   <= 1'b0;
         tx_disable <= 1'b0;
         test_sel   <= `PMAR_TEST_NORMAL;
      end
      else
      begin
         if (reg_write && sel_ctl)
         begin
            tx_disable <= reg_wdata[`PMAR_CTL_TXDIS_BIT];
            loopback   <= reg_wdata[`PMAR_CTL_LOOP_BIT];
         end
         else if (std_loop_write)
            loopback <= std_loop_wdata;
         if (reg_write && sel_tst)
            test_sel <= reg_wdata[`PMAR_TEST_LSB+2:`PMAR_TEST_LSB];
      end
   end

   // A new event wins over a clear in the same cycle so it is never lost.
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         jabber <= 1'b0;
      else if (jabber_event)
         jabber <= 1'b1;
      else if ((reg_read && sel_sta) || std_jabber_clear)
         jabber <= 1'b0;
   end
   assign std_jabber = jabber;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         reg_rdata <= 16'h0000;
      else if (reg_read)
      begin
         reg_rdata <= 16'h0000;
         if (sel_ctl)
         begin
            reg_rdata[`PMAR_CTL_RESET_BIT]  <= reset_busy;
            reg_rdata[`PMAR_CTL_TXDIS_BIT]  <= tx_disable;
            reg_rdata[`PMAR_CTL_LOWPWR_BIT] <= 1'b0;
            reg_rdata[`PMAR_CTL_MDROP_BIT]  <= 1'b1;
            reg_rdata[`PMAR_CTL_LOOP_BIT]   <= loopback;
         end
         else if (sel_sta)
         begin
            reg_rdata[`PMAR_STA_LOOPAB_BIT] <= 1'b1;
            reg_rdata[`PMAR_STA_LOWPWR_BIT] <= 1'b0;
            reg_rdata[`PMAR_STA_MDROP_BIT]  <= 1'b1;
            reg_rdata[`PMAR_STA_RXFLT_BIT]  <= 1'b1;
            reg_rdata[`PMAR_STA_JABBER_BIT] <= jabber | jabber_event;
         end
         else if (sel_tst)
            reg_rdata[`PMAR_TEST_LSB+2:`PMAR_TEST_LSB] <= test_sel;
         else if (sel_rev)
            reg_rdata <= {REV_MAJOR, REV_MINOR, REV_STAGE, REV_PATCH};
      end
   end

   assign std_loop      = loopback;
   assign loop_enable   = loopback;
   assign tx_power_down = tx_disable;
   assign mac_tx_grant  = mac_tx_req & ~tx_disable & ~reset_busy;
   assign test_mode     = test_sel;
endmodule
`default_nettype wire

//--- tb/pmar_properties.sv
// Purpose: Port checks for the bank.
// Assumes: Default revision values.
// Notes: Bound from the bench.
`timescale 1ns/1ps
`default_nettype none
module pmar_props
(
   input wire clk, rst, reg_read, reg_write, std_jabber, jabber_event, soft_reset,
   input wire mac_tx_req, mac_tx_grant, tx_power_down, loop_enable, std_loop,
   input wire std_loop_write, std_loop_wdata,
   input wire [2:0] map_select,
   input wire [15:0] reg_addr, reg_wdata, reg_rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire m3 = map_select == 3'h3;
   wire ctl = m3 && reg_addr == 16'h08F9;
   property p_grant; mac_tx_grant |-> mac_tx_req && !tx_power_down && !soft_reset; endproperty
   a_grant: assert property (p_grant) else $error("grant");
   property p_start; reg_write && ctl && reg_wdata[15] && !soft_reset |=> soft_reset; endproperty
   a_start: assert property (p_start) else $error("start");
   property p_end; $rose(soft_reset) |-> ##16 !soft_reset; endproperty
   a_end: assert property (p_end) else $error("length");
   property p_loop;
      std_loop_write && !(reg_write && ctl) && !soft_reset |=> std_loop == $past(std_loop_wdata) && loop_enable == std_loop;
   endproperty
   a_loop: assert property (p_loop) else $error("loop");
   property p_ctl; reg_read && ctl |=> (reg_rdata & 16'h3FFE) == 16'h0400; endproperty
   a_ctl: assert property (p_ctl) else $error("control");
   property p_stat; reg_read && m3 && reg_addr == 16'h08FA |=> (reg_rdata & 16'hFFFD) == 16'h2600; endproperty
   a_stat: assert property (p_stat) else $error("status");
   property p_jab; jabber_event |=> std_jabber; endproperty
   a_jab: assert property (p_jab) else $error("jabber");
   property p_rev; reg_read && map_select == 3'h4 && reg_addr == 16'h8000 |=> reg_rdata == 16'h254A; endproperty
   a_rev: assert property (p_rev) else $error("revision");
   c_reset: cover property (reg_write && ctl && reg_wdata[15]);
   c_jab: cover property (reg_read && std_jabber);
   c_loop: cover property (loop_enable);
endmodule
`default_nettype wire

//--- tb/pmar_host.sv
// Purpose: Host side of the register port.
// Assumes: One-cycle strobes at the falling edge.
// Notes: Map follows the address top bit.
`timescale 1ns/1ps
`default_nettype none
module pmar_host
(
   input  wire         clk,
   input  wire  [15:0] reg_rdata,
   output logic [2:0]  map_select,
   output logic [15:0] reg_addr,
   output logic        reg_write,
   output logic        reg_read,
   output logic [15:0] reg_wdata
);
   initial {map_select, reg_addr, reg_write, reg_read, reg_wdata} = '0;
   task acc(input w, input [15:0] a, input [15:0] v, output [15:0] d);
      @(negedge clk);
      {map_select, reg_addr, reg_wdata, reg_write, reg_read} = {a[15] ? 3'h4 : 3'h3, a, v, w, !w};
      @(negedge clk);
      {reg_write, reg_read} = 2'h0;
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

//--- tb/test_pmar_bank.sv
// Purpose: Bench for the bank.
// Assumes: Default revision values.
// Notes: Soft reset lasts 16 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module test_pmar_bank;
   logic clk = 0, rst = 1, std_loop_write = 0, std_loop_wdata = 0, std_jabber_clear = 0, jabber_event = 0;
   logic mac_tx_req = 1, reg_write, reg_read, reg_hit, std_loop, std_jabber, mac_tx_grant, tx_power_down;
   logic loop_enable, soft_reset;
   logic [2:0] map_select, test_mode;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, d;
   int failures = 0, check_count = 0, cyc = 0;
   always #10 clk = ~clk;
   pmar_host h(.*);
   pmar_bank dut(.*);
   task tally_and_finish;
      if (failures == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task rc(input [15:0] a, input [15:0] e);
      h.acc(1'b0, a, 16'h0000, d);
      `CK(d, e)
   endtask
   always @(posedge clk)
      if (++cyc == 3000)
      begin
         failures++;
         tally_and_finish;
      end
   initial
   begin
      repeat (6) @(negedge clk);
      rst = 0;
      rc(16'h08F9, 16'h0400);
      rc(16'h08FA, 16'h2600);
      rc(16'h08FB, 16'h0000);
      `CK(test_mode, 3'h0)
      rc(16'h08FC, 16'h0000);
      `CK(reg_hit, 1'b0)
      rc(16'h8000, 16'h254A);
      `CK(reg_hit, 1'b1)
      h.acc(1'b1, 16'h08F9, 16'h7BFF, d);
      rc(16'h08F9, 16'h4401);
      `CK({tx_power_down, loop_enable, std_loop, mac_tx_grant}, 4'hE)
      for (int c = 0; c < 5; c++)
      begin
         h.acc(1'b1, 16'h08FB, {c[2:0], 13'h1FFF}, d);
         rc(16'h08FB, {c[2:0], 13'h0000});
         `CK(test_mode, c[2:0])
      end
      @(negedge clk) jabber_event = 1;
      @(negedge clk) jabber_event = 0;
      `CK(std_jabber, 1'b1)
      rc(16'h08FA, 16'h2602);
      rc(16'h08FA, 16'h2600);
      @(negedge clk) jabber_event = 1;
      @(negedge clk) {jabber_event, std_jabber_clear} = 2'h1;
      @(negedge clk) std_jabber_clear = 0;
      `CK(std_jabber, 1'b0)
      h.acc(1'b1, 16'h08F9, 16'h8000, d);
      `CK(soft_reset, 1'b1)
      rc(16'h08F9, 16'h8400);
      repeat (14) @(negedge clk);
      rc(16'h08F9, 16'h0400);
      @(negedge clk) {std_loop_write, std_loop_wdata} = 2'h3;
      @(negedge clk) std_loop_write = 0;
      rc(16'h08F9, 16'h0401);
      tally_and_finish;
   end
endmodule
bind pmar_bank pmar_props chk(.*);
`default_nettype wire
